// *** drsc_top.sv ***
// loop state and reference selection controller
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`include "drsc_regs.svh"
// Behaviour
// - unmanaged: own logic picks loop state and reference from validity, priority
// - managed: state and reference follow control bits from the host
// - entering unmanaged keeps locked reference; only new failures move it
// - each loop has its own independent selection logic
// - automatic: best available priority, next best on failure
// - switch only on failures enabled by switch mask bits
// - switch mask resets to 1000, precise switch enable to zero
// - enabled failures put loop into auto-holdover in both modes
// - switch needed but nothing available: holdover, keep reference
// - holdover mask resets to 0111, precise holdover enable to one
// - leave auto-holdover once its causes have gone
// - three-bit priority per reference, smaller is better
// - priority 111 excludes the reference
// - equal priorities: lower-numbered reference wins
// - reset priorities rank references by index
// - no revert between equals; revert to strictly better at once
// - active reference shown in status bits in both modes
// - managed: reference follows control bits only
// - managed failed reference: stay in holdover until it is valid
// - reference select change: holdover, then normal on new reference
// - control and status bits available on general-purpose pins
// - one bit chooses hitless or glitchless switching
// - reference status code 00..11 for references zero..three
// - combined failure: loss of signal or enabled monitor indicator
module drsc_top
    import drsc_pkg::*;
(
    input  wire logic       CORE_CLK_I,
    input  wire logic       SYS_RST_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    input  wire logic       REG_WR_I,
    input  wire logic       REG_RD_I,
    output logic      [7:0] REG_RDATA_O,
    input  wire logic [3:0] REF_LOS_I,
    input  wire logic [3:0] REF_SCM_I,
    input  wire logic [3:0] REF_CFM_I,
    input  wire logic [3:0] REF_GST_I,
    input  wire logic [3:0] REF_PFM_I,
    input  wire logic       DPLL_LOCK_I,
    input  wire logic [4:0] GPIO_CTRL_I,
    output logic      [9:0] GPIO_STAT_O,
    output logic      [1:0] DPLL_STATE_O,
    output logic      [1:0] REF_SEL_O,
    output logic            HOLDOVER_O,
    output logic            HITLESS_O
);
    typedef struct packed {
        logic [7:0]      masks;
        logic [1:0]      precise_frequency_monitor;
        logic [3:0][2:0] prio;
        logic [6:0]      ctrl;
        drsc_state_t     st;
        logic [1:0]      ref_sel;
        logic [3:0]      avail_prev;
        logic [7:0]      rdata;
        logic [9:0]      gpio;
        logic [1:0]      code;
        logic            ho;
        logic            hitless;
        logic            lock;
        logic            mask_wr;
    } drsc_top_st_t;

    drsc_top_st_t q, d;
    logic [19:0]  fail_s;
    logic [4:0]   gp_s;
    logic [3:0]   los, single_cycle_monitor, coarse_frequency_monitor, guard_soak_timer, precise_frequency_monitor;
    logic [3:0]   sw_fail, ho_fail, comb_fail, avail;
    logic [3:0]   sw_m, ho_m;
    logic         mgd, pin;
    logic [1:0]   req_st, req_ref;
    logic         req_hitless;
    logic [1:0]   cur;
    logic [2:0]   cur_prio, best_prio;
    logic         cur_bad;

    // reset priority bytes, split below into the four three-bit fields
    localparam logic [7:0] prio_lo_rst = `DRSC_PRIO_LO_RST;
    localparam logic [7:0] prio_hi_rst = `DRSC_PRIO_HI_RST;

    drsc_pick_if pk ();

    drsc_sync #(.W(20)) u_sync_fail (
        .clk_i (CORE_CLK_I),
        .rst_i (SYS_RST_I),
        .d_i   ({REF_PFM_I, REF_GST_I, REF_CFM_I, REF_SCM_I, REF_LOS_I}),
        .q_o   (fail_s)
    );
    drsc_sync #(.W(5)) u_sync_gpio (
        .clk_i (CORE_CLK_I),
        .rst_i (SYS_RST_I),
        .d_i   (GPIO_CTRL_I),
        .q_o   (gp_s)
    );
    drsc_pick u_pick (
        .pk (pk)
    );

    assign {precise_frequency_monitor, guard_soak_timer, coarse_frequency_monitor, single_cycle_monitor, los} = fail_s;
    assign sw_m = q.masks[3:0];
    assign ho_m = q.masks[7:4];

    for (genvar i = 0; i < 4; i++) begin : g_ref
        assign sw_fail[i] = |({guard_soak_timer[i], coarse_frequency_monitor[i], single_cycle_monitor[i], los[i]} & sw_m) | (precise_frequency_monitor[i] & q.precise_frequency_monitor[0]);
        assign ho_fail[i] = |({guard_soak_timer[i], coarse_frequency_monitor[i], single_cycle_monitor[i], los[i]} & ho_m) | (precise_frequency_monitor[i] & q.precise_frequency_monitor[1]);
        assign comb_fail[i] = los[i] | |({guard_soak_timer[i], coarse_frequency_monitor[i], single_cycle_monitor[i]} & (sw_m[3:1] | ho_m[3:1]));
        assign avail[i] = !sw_fail[i] && !ho_fail[i] && (q.prio[i] != `DRSC_PRIO_OFF);
    end

    assign pk.cand = avail;
    assign pk.prio = q.prio;

    // pins may stand in for the control bits
    assign pin         = q.ctrl[`DRSC_CTRL_PIN];
    assign mgd         = q.ctrl[`DRSC_CTRL_MGD];
    assign req_st      = pin ? gp_s[1:0] : q.ctrl[`DRSC_CTRL_ST_LSB +: 2];
    assign req_ref     = pin ? gp_s[3:2] : q.ctrl[`DRSC_CTRL_REF_LSB +: 2];
    assign req_hitless = pin ? gp_s[4] : q.ctrl[`DRSC_CTRL_HITLESS];
    assign cur         = q.ref_sel;
    assign cur_prio    = q.prio[cur];
    assign best_prio   = q.prio[pk.best];
    assign cur_bad     = sw_fail[cur] || (cur_prio == `DRSC_PRIO_OFF);

    always_comb begin
        d         = q;
        d.rdata   = 8'h00;
        d.avail_prev = avail;
        d.hitless = req_hitless;
        d.lock    = DPLL_LOCK_I;

        if (REG_WR_I) begin
            case (REG_ADDR_I)
                `DRSC_ADDR_MASKS: begin
                    d.masks   = REG_WDATA_I;
                    d.mask_wr = 1'b1;
                end
                `DRSC_ADDR_PFM: begin
                    d.precise_frequency_monitor     = REG_WDATA_I[1:0];
                    d.mask_wr = 1'b1;
                end
                `DRSC_ADDR_PRIO_LO: begin
                    d.prio[0] = REG_WDATA_I[2:0];
                    d.prio[1] = REG_WDATA_I[6:4];
                end
                `DRSC_ADDR_PRIO_HI: begin
                    d.prio[2] = REG_WDATA_I[2:0];
                    d.prio[3] = REG_WDATA_I[6:4];
                end
                `DRSC_ADDR_CTRL: begin
                    d.ctrl = REG_WDATA_I[6:0];
                end
                default: begin
                end
            endcase
        end

        if (REG_RD_I) begin
            case (REG_ADDR_I)
                `DRSC_ADDR_MASKS:   d.rdata = q.masks;
                `DRSC_ADDR_PFM:     d.rdata = {6'h00, q.precise_frequency_monitor};
                `DRSC_ADDR_PRIO_LO: d.rdata = {1'b0, q.prio[1], 1'b0, q.prio[0]};
                `DRSC_ADDR_PRIO_HI: d.rdata = {1'b0, q.prio[3], 1'b0, q.prio[2]};
                `DRSC_ADDR_CTRL:    d.rdata = {1'b0, q.ctrl};
                // status shows state and active reference
                `DRSC_ADDR_STAT:    d.rdata = {2'h0, q.lock, q.ho, q.ref_sel, q.code};
                `DRSC_ADDR_FAIL:    d.rdata = {precise_frequency_monitor, comb_fail};
                default:            d.rdata = 8'h00;
            endcase
        end

        if (mgd) begin
            // new select forces a pass through holdover
            if (req_ref != cur) begin
                d.ref_sel = req_ref;
                d.st      = DRSC_HOLDOVER;
            end else begin
                case (req_st)
                    `DRSC_CODE_FREE: d.st = DRSC_FREERUN;
                    `DRSC_CODE_HOLD: d.st = DRSC_HOLDOVER;
                    default: d.st = (ho_fail[cur] || comb_fail[cur]) ? DRSC_HOLDOVER
                                                                     : DRSC_NORMAL;
                endcase
            end
        end else begin
            case (q.st)
                DRSC_FREERUN: begin
                    if (pk.found) begin
                        d.ref_sel = pk.best;
                        d.st      = DRSC_NORMAL;
                    end
                end
                default: begin
                    // only a new failure moves the inherited reference
                    if (cur_bad && pk.found) begin
                        d.ref_sel = pk.best;
                        d.st      = DRSC_NORMAL;
                    // nothing to switch to: holdover, reference kept
                    end else if (cur_bad || ho_fail[cur]) begin
                        d.st = DRSC_HOLDOVER;
                    end else begin
                        d.st = DRSC_NORMAL;
                        // revert only to strictly better, newly available
                        if (pk.found && best_prio < cur_prio && !q.avail_prev[pk.best]) begin
                            d.ref_sel = pk.best;
                        end
                    end
                end
            endcase
        end

        case (d.st)
            DRSC_NORMAL:   d.code = `DRSC_CODE_NORMAL;
            DRSC_HOLDOVER: d.code = `DRSC_CODE_HOLD;
            default:       d.code = `DRSC_CODE_FREE;
        endcase
        d.ho   = (d.st == DRSC_HOLDOVER);
        d.gpio = {d.hitless, d.code, d.lock, d.ho,
                  guard_soak_timer[d.ref_sel], coarse_frequency_monitor[d.ref_sel], single_cycle_monitor[d.ref_sel], d.ref_sel};
    end

    // this state belongs to one loop only
    always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            q         <= '0;
            q.masks   <= `DRSC_MASKS_RST;
            q.precise_frequency_monitor     <= `DRSC_PFM_RST;
            q.prio    <= {prio_hi_rst[6:4], prio_hi_rst[2:0],
                          prio_lo_rst[6:4], prio_lo_rst[2:0]};
            q.ctrl    <= `DRSC_CTRL_RST;
            q.st      <= DRSC_FREERUN;
            q.code    <= `DRSC_CODE_FREE;
            q.gpio    <= 10'h100;
        end else begin
            q <= d;
        end
    end

    assign REG_RDATA_O  = q.rdata;
    assign GPIO_STAT_O  = q.gpio;
    assign DPLL_STATE_O = q.code;
    assign REF_SEL_O    = q.ref_sel;
    assign HOLDOVER_O   = q.ho;
    assign HITLESS_O    = q.hitless;

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    property p_mask_rst;
        !q.mask_wr |-> (q.masks == `DRSC_MASKS_RST) && (q.precise_frequency_monitor == `DRSC_PFM_RST);
    endproperty
    a_mask_rst: assert property (p_mask_rst) else $error("mask reset value wrong");

    property p_no_off;
        !mgd && d.ref_sel != q.ref_sel |-> q.prio[d.ref_sel] != `DRSC_PRIO_OFF;
    endproperty
    a_no_off: assert property (p_no_off) else $error("excluded reference chosen");

    property p_keep_ref;
        !mgd && q.st != DRSC_FREERUN && cur_bad && !pk.found
            |=> $stable(q.ref_sel) && q.st == DRSC_HOLDOVER;
    endproperty
    a_keep_ref: assert property (p_keep_ref) else $error("holdover lost reference");

    property p_ho_exit;
        !mgd && q.st == DRSC_HOLDOVER && !cur_bad && !ho_fail[cur] |=> q.st == DRSC_NORMAL;
    endproperty
    a_ho_exit: assert property (p_ho_exit) else $error("holdover not left");

    sequence s_sel_change;
        mgd && req_ref != q.ref_sel && !REG_WR_I;
    endsequence
    sequence s_ho_on_new(logic [1:0] r);
        q.st == DRSC_HOLDOVER && q.ref_sel == r && HOLDOVER_O;
    endsequence
    property p_sel_change;
        logic [1:0] r;
        (s_sel_change, r = req_ref) |=> s_ho_on_new(r);
    endproperty
    a_sel_change: assert property (p_sel_change) else $error("select change skipped holdover");

    property p_mgd_ref;
        mgd && req_ref == q.ref_sel |=> $stable(q.ref_sel);
    endproperty
    a_mgd_ref: assert property (p_mgd_ref) else $error("managed reference moved");

    property p_failed_stay;
        mgd && req_ref == cur && req_st == `DRSC_CODE_NORMAL && comb_fail[cur]
            |=> q.st == DRSC_HOLDOVER;
    endproperty
    a_failed_stay: assert property (p_failed_stay) else $error("locked to failed ref");

    sequence s_stat_rd;
        REG_RD_I && REG_ADDR_I == `DRSC_ADDR_STAT;
    endsequence
    property p_stat;
        s_stat_rd |=> REG_RDATA_O[3:2] == $past(q.ref_sel) && REG_RDATA_O[1:0] == $past(q.code);
    endproperty
    a_stat: assert property (p_stat) else $error("status read wrong");

    // no candidate beats the winner, ties go to the lower index
    for (genvar j = 0; j < 4; j++) begin : g_pick_chk
        property p_pick_order;
            pk.found && avail[j] |-> (q.prio[pk.best] < q.prio[j])
                || (q.prio[pk.best] == q.prio[j] && pk.best <= 2'(j));
        endproperty
        a_pick_order: assert property (p_pick_order) else $error("picker order wrong");
    end

    property p_mgd_free;
        mgd && req_ref == cur && req_st == `DRSC_CODE_FREE |=> q.st == DRSC_FREERUN;
    endproperty
    a_mgd_free: assert property (p_mgd_free) else $error("freerun request ignored");

    property p_hitless;
        !pin |=> HITLESS_O == $past(q.ctrl[`DRSC_CTRL_HITLESS]);
    endproperty
    a_hitless: assert property (p_hitless) else $error("switching style wrong");

    // healthy current reference and nothing newly available: no move
    property p_hold_ref;
        !mgd && q.st != DRSC_FREERUN && !cur_bad && avail == q.avail_prev
            |=> $stable(q.ref_sel);
    endproperty
    a_hold_ref: assert property (p_hold_ref) else $error("reference moved without cause");
endmodule : drsc_top

// *** drsc_regs.svh ***
// register offsets, field positions and reset values of the reference state controller
`ifndef DRSC_REGS_SVH
`define DRSC_REGS_SVH
`define DRSC_ADDR_MASKS     8'h34
`define DRSC_ADDR_PFM       8'hf4
`define DRSC_ADDR_PRIO_LO   8'h40
`define DRSC_ADDR_PRIO_HI   8'h41
`define DRSC_ADDR_CTRL      8'h42
`define DRSC_ADDR_STAT      8'h43
`define DRSC_ADDR_FAIL      8'h44
`define DRSC_MASKS_RST      8'h78
`define DRSC_PFM_RST        2'h2
`define DRSC_PRIO_LO_RST    8'h10
`define DRSC_PRIO_HI_RST    8'h32
`define DRSC_CTRL_RST       7'h00
`define DRSC_PRIO_OFF       3'h7
`define DRSC_CTRL_MGD       0
`define DRSC_CTRL_ST_LSB    1
`define DRSC_CTRL_REF_LSB   3
`define DRSC_CTRL_HITLESS   5
`define DRSC_CTRL_PIN       6
`define DRSC_CODE_NORMAL    2'h0
`define DRSC_CODE_HOLD      2'h1
`define DRSC_CODE_FREE      2'h2
`endif

// *** drsc_pkg.sv ***
// types shared by the reference state controller
package drsc_pkg;
    typedef enum logic [1:0] {DRSC_FREERUN, DRSC_NORMAL, DRSC_HOLDOVER} drsc_state_t;
endpackage : drsc_pkg

// *** drsc_pick_if.sv ***
// candidate set and winner between the controller and the priority picker
`timescale 1ns/1ns
interface drsc_pick_if;
    logic [3:0]      cand;
    logic [3:0][2:0] prio;
    logic [1:0]      best;
    logic            found;
    modport picker (input cand, input prio, output best, output found);
    modport user   (output cand, output prio, input best, input found);
endinterface : drsc_pick_if

// *** drsc_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module drsc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } drsc_sync_st_t;
    drsc_sync_st_t st_q, st_d;
    always_comb begin
        st_d    = st_q;
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign q_o = st_q.s2;
endmodule : drsc_sync

// *** drsc_pick.sv ***
// best-priority picker over four references
`timescale 1ns/1ns
module drsc_pick (
    drsc_pick_if.picker pk
);
    logic [2:0] bp;
    always_comb begin
        pk.best  = 2'h0;
        pk.found = 1'b0;
        bp       = 3'h7;
        // walk down so that a tie leaves the lower index
        for (int i = 3; i >= 0; i--) begin
            if (pk.cand[i] && (!pk.found || pk.prio[i] <= bp)) begin
                pk.best  = 2'(i);
                pk.found = 1'b1;
                bp       = pk.prio[i];
            end
        end
    end
endmodule : drsc_pick

// *** drsc_host.sv ***
// host controller model issuing register cycles
`timescale 1ns/1ns
module drsc_host (
    input  wire logic       clk_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    input  wire logic [7:0] rdata_i
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        // released data must not look valid
        wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        #1;
        d = rdata_i;
    endtask : rd
endmodule : drsc_host

// *** tb.sv ***
// self-checking bench of the reference state controller
`timescale 1ns/1ns
module tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr, wdata, rdata, rv;
    logic       wr, rd, hold, hit;
    logic [3:0] los = '0, single_cycle_monitor = '0, coarse_frequency_monitor = '0, guard_soak_timer = '0, precise_frequency_monitor = '0;
    logic       lock = 1'b0;
    logic [4:0] gpio_ctrl = '0;
    logic [9:0] gpio_stat;
    logic [1:0] st, sel;
    logic [31:0] seed = 32'h4d1da096;
    logic [7:0] ra [5] = '{8'h34, 8'hf4, 8'h40, 8'h41, 8'h55};
    logic [7:0] rr [5] = '{8'h78, 8'h02, 8'h10, 8'h32, 8'h00};
    int failures = 0, samples_checked = 0, cycles = 0;
    int m_st, m_ref, m_hit, r, b;
    int prio [4];

    always #50 clk = ~clk;

    drsc_host i_drsc_host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
                           .rd_o(rd), .rdata_i(rdata));
    drsc_top i_drsc_top (.CORE_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
        .REF_LOS_I(los), .REF_SCM_I(single_cycle_monitor), .REF_CFM_I(coarse_frequency_monitor), .REF_GST_I(guard_soak_timer),
        .REF_PFM_I(precise_frequency_monitor), .DPLL_LOCK_I(lock), .GPIO_CTRL_I(gpio_ctrl),
        .GPIO_STAT_O(gpio_stat), .DPLL_STATE_O(st), .REF_SEL_O(sel),
        .HOLDOVER_O(hold), .HITLESS_O(hit));

    task automatic test_done();
        if (failures == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_drsc_host.rd(a, rv);
        chk("read data", {2'b00, e}, {2'b00, rv});
    endtask : rchk

    task automatic outs();
        chk("loop state", 10'(m_st), {8'h00, st});
        chk("active reference", 10'(m_ref), {8'h00, sel});
        chk("holdover flag", 10'(m_st == 1), {9'h000, hold});
        chk("hitless flag", 10'(m_hit), {9'h000, hit});
        chk("pin status", {1'(m_hit), 2'(m_st), lock, 1'(m_st == 1), guard_soak_timer[m_ref], coarse_frequency_monitor[m_ref],
            single_cycle_monitor[m_ref], 2'(m_ref)}, gpio_stat);
    endtask : outs

    // synchroniser plus state steps, with margin
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask : settle

    task automatic fails(input logic [3:0] l, s, c, g, p);
        @(posedge clk);
        los <= l;
        single_cycle_monitor <= s;
        coarse_frequency_monitor <= c;
        guard_soak_timer <= g;
        precise_frequency_monitor <= p;
        settle();
    endtask : fails

    initial begin
        // reset starts as a level, so it only takes hold at the first edge
        @(posedge clk);
        #1;
        chk("reset state", 10'h002, {8'h00, st});
        chk("reset pins", 10'h100, gpio_stat);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle();
        m_st = 0;
        m_ref = 0;
        m_hit = 0;
        outs();
        foreach (ra[i]) rchk(ra[i], rr[i]);
        fails(4'h0, 4'h0, 4'h0, 4'h1, 4'h8);
        m_ref = 1;
        outs();
        rchk(8'h44, 8'h81);
        fails(4'h0, 4'h2, 4'h0, 4'h1, 4'h0);
        m_st = 1;
        outs();
        fails(4'h0, 4'h0, 4'h0, 4'h1, 4'h0);
        m_st = 0;
        outs();
        // only loss of signal may switch now, and only a precise frequency failure forces holdover
        i_drsc_host.wr(8'h34, 8'h01);
        rchk(8'h34, 8'h01);
        settle();
        m_ref = 0;
        outs();
        fails(4'h1, 4'h0, 4'h0, 4'h1, 4'h0);
        m_ref = 1;
        outs();
        fails(4'h0, 4'h0, 4'h0, 4'h1, 4'h0);
        m_ref = 0;
        outs();
        i_drsc_host.wr(8'h40, 8'h00);
        i_drsc_host.wr(8'h41, 8'h00);
        fails(4'h1, 4'h0, 4'h0, 4'h0, 4'h0);
        m_ref = 1;
        outs();
        fails(4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        outs();
        i_drsc_host.wr(8'h40, 8'h70);
        settle();
        m_ref = 0;
        outs();
        fails(4'hf, 4'h0, 4'h0, 4'h0, 4'h0);
        m_st = 1;
        outs();
        fails(4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        m_st = 0;
        outs();
        // ref one selectable again before the random priorities, so no revert sneaks in
        i_drsc_host.wr(8'h40, 8'h10);
        settle();
        outs();
        i_drsc_host.wr(8'h34, 8'h08);
        for (int i = 0; i < 20; i++) begin
            seed = xs(seed);
            for (int k = 0; k < 4; k++) prio[k] = int'(seed[3*k +: 3]) % 7;
            i_drsc_host.wr(8'h40, {1'b0, 3'(prio[1]), 1'b0, 3'(prio[0])});
            i_drsc_host.wr(8'h41, {1'b0, 3'(prio[3]), 1'b0, 3'(prio[2])});
            fails(4'h0, 4'h0, 4'h0, 4'hf, 4'h0);
            m_st = 1;
            outs();
            @(posedge clk);
            lock <= seed[31];
            fails(4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
            b = 0;
            for (int k = 1; k < 4; k++) if (prio[k] < prio[b]) b = k;
            if (prio[m_ref] != prio[b]) m_ref = b;
            m_st = 0;
            outs();
            rchk(8'h43, {2'b00, lock, 1'b0, 2'(m_ref), 2'b00});
        end
        i_drsc_host.wr(8'h34, 8'h78);
        r = (m_ref + 1) % 4;
        i_drsc_host.wr(8'h42, 8'h21 | 8'(r << 3));
        @(posedge clk);
        #1;
        m_st = 1;
        m_ref = r;
        m_hit = 1;
        outs();
        settle();
        m_st = 0;
        outs();
        r = (r + 1) % 4;
        fails(4'(1 << r), 4'h0, 4'h0, 4'h0, 4'h0);
        i_drsc_host.wr(8'h42, 8'h21 | 8'(r << 3));
        settle();
        m_st = 1;
        m_ref = r;
        outs();
        fails(4'h0, 4'h0, 4'h0, 4'h0, 4'h0);
        m_st = 0;
        outs();
        for (int q = 0; q < 4; q++) begin
            i_drsc_host.wr(8'h42, 8'h21 | 8'(r << 3) | 8'(q << 1));
            settle();
            m_st = (q == 3) ? 0 : q;
            outs();
        end
        i_drsc_host.wr(8'h42, 8'h20);
        settle();
        outs();
        r = (r + 1) % 4;
        @(posedge clk);
        gpio_ctrl <= {1'b0, 2'(r), 2'b01};
        i_drsc_host.wr(8'h42, 8'h41);
        settle();
        m_st = 1;
        m_ref = r;
        m_hit = 0;
        outs();
        test_done();
    end
endmodule : tb
